// File: rtl/cfvl_pkg.sv
/*
  Package for the charger fault and input voltage limit register pair.
  Holds offsets, field positions, reset values, fault codes and carrier structs.
  Assumes a byte-wide register port with an 8-bit address, driven on CLOCK_IN.
*/
package cfvl_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets and widths.
  localparam int unsigned CFVL_DATA_W = 8;
  localparam int unsigned CFVL_ADDR_W = 8;
  localparam int unsigned CFVL_CODE_W = 7;
  localparam logic [7:0] CFVL_FAULT_FLAGS_OFS = 8'h0C;
  localparam logic [7:0] CFVL_VIN_LIMIT_OFS = 8'h0D;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions in the fault register.
  localparam int unsigned CFVL_WDOG_BIT = 7;
  localparam int unsigned CFVL_BOOST_BIT = 6;
  localparam int unsigned CFVL_CHARGE_LSB = 4;
  localparam int unsigned CFVL_BATTERY_BIT = 3;
  localparam int unsigned CFVL_THERM_LSB = 0;
  // Field positions in the limit register.
  localparam int unsigned CFVL_ABS_SEL_BIT = 7;
  localparam int unsigned CFVL_FLOOR_LSB = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and clamp floor.
  localparam logic [7:0] CFVL_VIN_LIMIT_RST = 8'h12;
  localparam logic [6:0] CFVL_FLOOR_CODE_RST = 7'h12;
  localparam logic [6:0] CFVL_FLOOR_CODE_MIN = 7'h0D;
  localparam logic [7:0] CFVL_READ_IDLE = 8'h00;
  // Threshold scale in millivolts: offset plus step times code.
  localparam int unsigned CFVL_OFFSET_MV = 2600;
  localparam int unsigned CFVL_STEP_MV = 100;
  localparam int unsigned CFVL_MV_W = 14;

  //////////////////////////////////////////////////////////////////////////////
  // Fault codes.
  typedef enum logic [1:0] {
    CFVL_CHG_NORMAL = 2'h0,
    CFVL_CHG_INPUT = 2'h1,
    CFVL_CHG_THERMAL = 2'h2,
    CFVL_CHG_TIMER = 2'h3
  } cfvl_charge_code_t;

  typedef enum logic [2:0] {
    CFVL_THERM_NORMAL = 3'h0,
    CFVL_THERM_WARM = 3'h2,
    CFVL_THERM_COOL = 3'h3,
    CFVL_THERM_COLD = 3'h5,
    CFVL_THERM_HOT = 3'h6
  } cfvl_therm_code_t;

  // Raw fault conditions from the analog side, one level each.
  typedef struct packed {
    logic watchdog_expired;
    logic boost_overload;
    logic boost_overvoltage;
    logic boost_battery_low;
    logic input_fault;
    logic thermal_shutdown;
    logic safety_timer_expired;
    logic battery_overvoltage;
    logic boost_mode;
    logic therm_warm;
    logic therm_cool;
    logic therm_cold;
    logic therm_hot;
  } cfvl_fault_in_t;

  // Host register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfvl_req_t;

endpackage : cfvl_pkg

// File: rtl/cfvl_sync2.sv
/*
  Two-flop synchroniser for a bus of asynchronous levels.
  Assumes the inputs are slow levels; no multi-bit coherency is promised.
*/
`timescale 1ns/1ps
module cfvl_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_in, // Core clock.
  input wire logic rst_in, // Asynchronous reset, active high.
  input wire logic [WIDTH-1:0] async_in, // Levels from another domain.
  output logic [WIDTH-1:0] sync_out // Synchronised levels.
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cfvl_sync_state_t;

  cfvl_sync_state_t state_reg;
  cfvl_sync_state_t state_next;

  initial begin
    if (WIDTH < 1) $error("cfvl_sync2 needs WIDTH of at least 1.");
  end

  // The first stage feeds only the second stage.
  always_comb begin
    state_next.meta = async_in;
    state_next.stable = state_reg.meta;
  end

  // Both stages clear under reset.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;

endmodule : cfvl_sync2

// File: rtl/cfvl_regs.sv
/*
  Fault status and input voltage limit registers of a battery charger.
  Assumes a one-cycle read or write strobe from the serial control front end on
  CLOCK_IN, and fault levels arriving asynchronously from the analog side.
*/
`timescale 1ns/1ps
module cfvl_regs #(
  parameter int unsigned CODE_W = cfvl_pkg::CFVL_CODE_W
) (
  input wire logic CLOCK_IN, // Core clock, 100 MHz.
  input wire logic RST_IN, // Register reset, asynchronous, active high.
  input wire cfvl_pkg::cfvl_req_t REQ_IN, // Host register request.
  input wire cfvl_pkg::cfvl_fault_in_t FAULT_IN, // Asynchronous fault levels.
  input wire logic [CODE_W-1:0] RELATIVE_CODE_IN, // Internally computed threshold code.
  output logic [7:0] RDATA_OUT, // Read data, valid with RVALID_OUT.
  output logic RVALID_OUT, // Read answer pulse.
  output logic [7:0] FAULT_FLAGS_OUT, // Live fault register image.
  output logic [CODE_W-1:0] FLOOR_CODE_OUT, // Effective clamped threshold code.
  output logic [cfvl_pkg::CFVL_MV_W-1:0] FLOOR_MV_OUT // Effective threshold in millivolts.
);

  // Elaboration checks: the images are built for a byte-wide port and a 7-bit code.
  initial begin
    if (CODE_W != cfvl_pkg::CFVL_CODE_W) $error("cfvl_regs supports a 7-bit code only.");
    if (cfvl_pkg::CFVL_DATA_W != 8) begin
      $error("cfvl_regs needs an 8-bit data path.");
    end
    if (cfvl_pkg::CFVL_OFFSET_MV + cfvl_pkg::CFVL_STEP_MV * (2 ** CODE_W - 1) >=
        2 ** cfvl_pkg::CFVL_MV_W) begin
      $error("cfvl_regs millivolt output is too narrow for the top code.");
    end
    if (cfvl_pkg::CFVL_FLOOR_CODE_RST < cfvl_pkg::CFVL_FLOOR_CODE_MIN) begin
      $error("cfvl_regs reset code lies below the clamp floor.");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timing: a request is taken at the clock edge where its strobe is high, and the
  // read answer stands for exactly the next cycle; the data holds until the next read.
  // A fault level needs two edges to cross the synchroniser and one more to reach the
  // image, so a fault shorter than about one cycle may never be seen. That is the price
  // of a safe crossing from the analog comparators.

  //////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic absolute_threshold_select;
    logic [CODE_W-1:0] input_voltage_floor_code;
    logic [7:0] fault_flags;
    logic [7:0] rdata;
    logic rvalid;
    logic [CODE_W-1:0] floor_eff;
    logic [cfvl_pkg::CFVL_MV_W-1:0] floor_mv;
  } cfvl_state_t;

  cfvl_state_t state_reg;
  cfvl_state_t state_next;
  cfvl_pkg::cfvl_fault_in_t fault_sync;

  // Fault levels come from analog comparators, so they are synchronised first.
  cfvl_sync2 #(
    .WIDTH($bits(cfvl_pkg::cfvl_fault_in_t))
  ) u_fault_sync (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .async_in(FAULT_IN),
    .sync_out(fault_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Fault encoding helpers.
  function automatic logic [1:0] charge_code(input cfvl_pkg::cfvl_fault_in_t f);
    // The safety timer dominates, then thermal shutdown, then input faults.
    if (f.safety_timer_expired) begin
      charge_code = cfvl_pkg::CFVL_CHG_TIMER;
    end else if (f.thermal_shutdown) begin
      charge_code = cfvl_pkg::CFVL_CHG_THERMAL;
    end else if (f.input_fault) begin
      charge_code = cfvl_pkg::CFVL_CHG_INPUT;
    end else begin
      charge_code = cfvl_pkg::CFVL_CHG_NORMAL;
    end
  endfunction : charge_code

  function automatic logic [2:0] therm_code(input cfvl_pkg::cfvl_fault_in_t f);
    // Extreme temperatures outrank warm or cool; boost mode hides warm and cool.
    if (f.therm_hot) begin
      therm_code = cfvl_pkg::CFVL_THERM_HOT;
    end else if (f.therm_cold) begin
      therm_code = cfvl_pkg::CFVL_THERM_COLD;
    end else if (!f.boost_mode && f.therm_warm) begin
      therm_code = cfvl_pkg::CFVL_THERM_WARM;
    end else if (!f.boost_mode && f.therm_cool) begin
      therm_code = cfvl_pkg::CFVL_THERM_COOL;
    end else begin
      therm_code = cfvl_pkg::CFVL_THERM_NORMAL;
    end
  endfunction : therm_code

  //////////////////////////////////////////////////////////////////////////////
  // Threshold helpers.
  // floor clamp
  function automatic logic [CODE_W-1:0] clamp_code(input logic [CODE_W-1:0] code);
    // The stored code stays raw so a read shows what was written; only the result clamps.
    if (code < CODE_W'(cfvl_pkg::CFVL_FLOOR_CODE_MIN)) begin
      clamp_code = CODE_W'(cfvl_pkg::CFVL_FLOOR_CODE_MIN);
    end else begin
      clamp_code = code;
    end
  endfunction : clamp_code

  function automatic logic [cfvl_pkg::CFVL_MV_W-1:0] code_to_mv(input logic [CODE_W-1:0] code);
    // The top code lands at 15300 mV, which fits the result, so the cut drops only zeros.
    code_to_mv = cfvl_pkg::CFVL_MV_W'(cfvl_pkg::CFVL_OFFSET_MV +
        cfvl_pkg::CFVL_STEP_MV * code);
  endfunction : code_to_mv

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    logic [CODE_W-1:0] code_raw;
    logic [7:0] limit_image;
    logic hit_flags;
    logic hit_limit;
    logic limit_write;
    code_raw = '0;
    limit_image = '0;
    // Address decode; an address outside the pair reads as idle and writes nowhere.
    hit_flags = (REQ_IN.addr == cfvl_pkg::CFVL_FAULT_FLAGS_OFS);
    hit_limit = (REQ_IN.addr == cfvl_pkg::CFVL_VIN_LIMIT_OFS);
    limit_write = REQ_IN.wr && hit_limit;
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.fault_flags[cfvl_pkg::CFVL_WDOG_BIT] = fault_sync.watchdog_expired;
    state_next.fault_flags[cfvl_pkg::CFVL_BOOST_BIT] = fault_sync.boost_overload |
        fault_sync.boost_overvoltage | fault_sync.boost_battery_low;
    state_next.fault_flags[cfvl_pkg::CFVL_CHARGE_LSB +: 2] = charge_code(fault_sync);
    state_next.fault_flags[cfvl_pkg::CFVL_BATTERY_BIT] = fault_sync.battery_overvoltage;
    state_next.fault_flags[cfvl_pkg::CFVL_THERM_LSB +: 3] = therm_code(fault_sync);
    if (!state_reg.absolute_threshold_select) begin
      state_next.input_voltage_floor_code = RELATIVE_CODE_IN;
    end
    // writes to the fault register fall through with no effect.
    if (limit_write) begin
      state_next.absolute_threshold_select = REQ_IN.wdata[cfvl_pkg::CFVL_ABS_SEL_BIT];
      // host absolute code
      // The select value held before this write gates the code, so arming the absolute
      // mode and loading a code take two writes; a single write cannot do both.
      if (state_reg.absolute_threshold_select) begin
        state_next.input_voltage_floor_code = REQ_IN.wdata[cfvl_pkg::CFVL_FLOOR_LSB +: CODE_W];
      end
    end
    code_raw = state_next.input_voltage_floor_code;
    state_next.floor_eff = clamp_code(code_raw);
    state_next.floor_mv = code_to_mv(state_next.floor_eff);
    // live fault readback
    // A read in the same cycle as a write returns the image held before that write.
    limit_image = {state_reg.absolute_threshold_select, state_reg.input_voltage_floor_code};
    if (REQ_IN.rd) begin
      state_next.rvalid = 1'b1;
      if (hit_flags) begin
        state_next.rdata = state_reg.fault_flags;
      end else if (hit_limit) begin
        state_next.rdata = limit_image;
      end else begin
        state_next.rdata = cfvl_pkg::CFVL_READ_IDLE;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg.absolute_threshold_select <= 1'b0;
      state_reg.input_voltage_floor_code <= cfvl_pkg::CFVL_FLOOR_CODE_RST;
      state_reg.fault_flags <= '0;
      state_reg.rdata <= cfvl_pkg::CFVL_READ_IDLE;
      state_reg.rvalid <= 1'b0;
      state_reg.floor_eff <= cfvl_pkg::CFVL_FLOOR_CODE_RST;
      state_reg.floor_mv <= cfvl_pkg::CFVL_MV_W'(cfvl_pkg::CFVL_OFFSET_MV +
          cfvl_pkg::CFVL_STEP_MV * cfvl_pkg::CFVL_FLOOR_CODE_RST);
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a flop.
  assign RDATA_OUT = state_reg.rdata;
  assign RVALID_OUT = state_reg.rvalid;
  assign FAULT_FLAGS_OUT = state_reg.fault_flags;
  assign FLOOR_CODE_OUT = state_reg.floor_eff;
  assign FLOOR_MV_OUT = state_reg.floor_mv;

endmodule : cfvl_regs

// File: bench/cfvl_regs_props.sv
/*
  Checker for the fault and input voltage limit registers.
  Sees only the top ports; bound from the testbench top file.
*/
`timescale 1ns/1ps
module cfvl_regs_props #(
  parameter int unsigned CODE_W = 7
) (
  input wire logic CLOCK_IN, // Core clock.
  input wire logic RST_IN, // Reset, active high.
  input wire cfvl_pkg::cfvl_req_t REQ_IN, // Host request.
  input wire cfvl_pkg::cfvl_fault_in_t FAULT_IN, // Fault levels.
  input wire logic [CODE_W-1:0] RELATIVE_CODE_IN, // Relative code.
  input wire logic [7:0] RDATA_OUT, // Read data.
  input wire logic RVALID_OUT, // Read answer.
  input wire logic [7:0] FAULT_FLAGS_OUT, // Fault image.
  input wire logic [CODE_W-1:0] FLOOR_CODE_OUT, // Clamped code.
  input wire logic [cfvl_pkg::CFVL_MV_W-1:0] FLOOR_MV_OUT // Threshold in mV.
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // Faults are held four edges, one more than the three needed to cross the synchroniser and the register.
  sequence boost_held;
    (FAULT_IN.boost_overload || FAULT_IN.boost_overvoltage || FAULT_IN.boost_battery_low) [*4];
  endsequence
  sequence timer_held;
    FAULT_IN.safety_timer_expired [*4];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (REQ_IN.rd |=> RVALID_OUT) else $error("read not answered");
  a_no_stray: assert property (!REQ_IN.rd |=> !RVALID_OUT) else $error("stray answer");
  a_watchdog_bit: assert property ($stable(FAULT_IN.watchdog_expired) [*4] |=>
    FAULT_FLAGS_OUT[7] == $past(FAULT_IN.watchdog_expired)) else $error("watchdog bit wrong");
  a_boost_bit: assert property (boost_held |=> FAULT_FLAGS_OUT[6]) else $error("boost bit");
  a_timer_code: assert property (timer_held |=> FAULT_FLAGS_OUT[5:4] == 2'h3) else $error("timer");
  a_battery_bit: assert property ($stable(FAULT_IN.battery_overvoltage) [*4] |=>
    FAULT_FLAGS_OUT[3] == $past(FAULT_IN.battery_overvoltage)) else $error("battery bit wrong");
  a_therm_codes: assert property (FAULT_FLAGS_OUT[2:0] inside {3'h0, 3'h2, 3'h3, 3'h5, 3'h6})
    else $error("thermistor code illegal");
  a_boost_therm: assert property (FAULT_IN.boost_mode [*4] |=>
    FAULT_FLAGS_OUT[2:0] inside {3'h0, 3'h5, 3'h6}) else $error("boost thermistor code");
  a_floor_clamp: assert property (FLOOR_CODE_OUT >= 7'h0D) else $error("code below floor");
  a_mv_scale: assert property (FLOOR_MV_OUT ==
    cfvl_pkg::CFVL_OFFSET_MV + cfvl_pkg::CFVL_STEP_MV * FLOOR_CODE_OUT)
    else $error("millivolt scale wrong");
endmodule : cfvl_regs_props

// File: bench/testbench.sv
/*
  Self-checking bench for the fault and input voltage limit registers.
  Drives every port directly; no partner model is needed.
*/
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cfvl_pkg::cfvl_req_t req = '0;
  cfvl_pkg::cfvl_fault_in_t flt = '0;
  logic [6:0] rel = 7'h12;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] fflags;
  logic [6:0] fcode;
  logic [13:0] fmv;
  int failures = 0;
  int checks = 0;
  // Fault stimulus and the register image each must produce.
  localparam logic [12:0] FV [15] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100,
    13'h0080, 13'h0040, 13'h0020, 13'h0008, 13'h0004, 13'h0002, 13'h0001, 13'h0018, 13'h0011,
    13'h0000};
  localparam logic [7:0] FE [15] = '{8'h80, 8'h40, 8'h40, 8'h40, 8'h10, 8'h20, 8'h30, 8'h08,
    8'h02, 8'h03, 8'h05, 8'h06, 8'h00, 8'h06, 8'h00};

  // Free-running core clock.
  always #5 clk = ~clk;

  cfvl_regs #(.CODE_W(7)) u_dut (.CLOCK_IN(clk), .RST_IN(rst), .REQ_IN(req), .FAULT_IN(flt),
    .RELATIVE_CODE_IN(rel), .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .FAULT_FLAGS_OUT(fflags),
    .FLOOR_CODE_OUT(fcode), .FLOOR_MV_OUT(fmv));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Requests last one edge; the answer stands in the cycle after the read edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1 req = '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 req = '0;
    chk(rvalid, 1'b1);
    d = rdata;
  endtask : rd

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    rd(8'h0D, d);
    chk(d, 8'h12);
    chk(fmv, 14'h1130);
    rd(8'h0E, d);
    chk(d, 8'h00);
  endtask : t_reset

  task automatic t_relative();
    logic [7:0] d;
    rel = 7'h20;
    wr(8'h0D, 8'h05);
    chk(fcode, 7'h20);
    rd(8'h0D, d);
    chk(d, 8'h20);
    chk(fmv, 14'h16A8);
    rel = 7'h05;
    repeat (3) @(posedge clk);
    #1 chk(fcode, 7'h0D);
  endtask : t_relative

  task automatic t_absolute();
    logic [7:0] d;
    wr(8'h0D, 8'h80);
    wr(8'h0D, 8'h85);
    rel = 7'h30;
    rd(8'h0D, d);
    chk(d, 8'h85);
    chk(fmv, 14'h0F3C);
    wr(8'h0D, 8'hFF);
    rd(8'h0D, d);
    chk(d, 8'hFF);
    chk(fmv, 14'h3BC4);
    @(posedge clk);
    #1 req = '{wr: 1'b1, rd: 1'b1, addr: 8'h0D, wdata: 8'h81};
    @(posedge clk);
    #1 req = '0;
    chk(rdata, 8'hFF);
    rd(8'h0D, d);
    chk(d, 8'h81);
    chk(fcode, 7'h0D);
  endtask : t_absolute

  task automatic t_faults();
    logic [7:0] d;
    for (int i = 0; i < 15; i++) begin
      flt = FV[i];
      repeat (5) @(posedge clk);
      #1 chk(fflags, FE[i]);
      wr(8'h0C, 8'hFF);
      rd(8'h0C, d);
      chk(d, FE[i]);
    end
  endtask : t_faults

  task automatic t_rereset();
    logic [7:0] d;
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 chk(fcode, 7'h12);
    chk(fmv, 14'h1130);
    chk(rvalid, 1'b0);
    rst = 1'b0;
    // Select must come back clear, so the stored code tracks the relative input again.
    rd(8'h0D, d);
    chk(d, 8'h30);
  endtask : t_rereset

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence, with a bounded guard against a hang.
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_relative();
    t_absolute();
    t_faults();
    t_rereset();
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : testbench

bind cfvl_regs cfvl_regs_props #(.CODE_W(CODE_W)) u_props (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
  .REQ_IN(REQ_IN), .FAULT_IN(FAULT_IN), .RELATIVE_CODE_IN(RELATIVE_CODE_IN),
  .RDATA_OUT(RDATA_OUT), .RVALID_OUT(RVALID_OUT), .FAULT_FLAGS_OUT(FAULT_FLAGS_OUT),
  .FLOOR_CODE_OUT(FLOOR_CODE_OUT), .FLOOR_MV_OUT(FLOOR_MV_OUT));
